// ===== timer0_counter.sv
// Operation
// - Source select clear: timer advances once per instruction cycle without prescaler.
// - A software write to the count suppresses counting for two instruction cycles.
// - Source select set: count external input edges; edge select one means falling.
// - External input is synchronised before counting; increment may lag the edge.
// - An eight-bit prescaler exists and is not software visible.
// - Assignment bit clear: prescaler feeds timer, ratio 1:2 to 1:256.
// - A count write clears the prescaler when assignment bit is clear, leaving assignment unchanged.
// - Software may change prescaler assignment at any time.
// - Overflow flag sets on wrap FFh to 00h, or FFFFh to 0000h.
// - Clearing the enable masks the interrupt; software clears flag before re-enabling.
// - Overflow interrupt never wakes the processor from low-power sleep.
// - Live high byte is never directly accessed; a buffer register stands between.
// - Reading the low byte copies the live high byte into the buffer.
// - Writing the low byte loads the live high byte from the buffer.
//
// Holds the whole timer/counter with its register port and interrupt logic.
// Assumes one 20 MHz clock; the count pin is asynchronous to it.
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module timer0_counter
   import timer0_counter_pkg::*;
(
   input  wire logic              mclk_i,
   input  wire logic              rst_n_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   input  wire logic              external_count_input_i,
   input  wire logic              sleep_i,
   output logic      [DATA_W-1:0] rdata_o,
   output logic                   irq_o,
   output logic                   wake_o
);

////////////////////////////////////////////////////////////////////////////////

   logic [7:0] timer_control_q;
   logic [7:0] int_ctrl_q;
   logic       ovf_status_q;
   logic       ovf_mask_q;
   logic [7:0] cycle_div_q;
   logic [7:0] div_cnt_q;
   logic [7:0] count_low_q;
   logic [7:0] count_live_high_q;
   logic [7:0] count_high_buffer_q;
   logic [7:0] prescaler_q;
   logic [1:0] holdoff_q;
   logic       ext_meta_q;
   logic       ext_sync_q;
   logic       ext_prev_q;

   // Decode.
   wire wr_low   = wr_i && (addr_i == ADDR_COUNT_LOW);
   wire wr_high  = wr_i && (addr_i == ADDR_COUNT_HIGH);
   wire wr_tc    = wr_i && (addr_i == ADDR_TIMER_CTRL);
   wire wr_ic    = wr_i && (addr_i == ADDR_INT_CTRL);
   wire wr_st    = wr_i && (addr_i == ADDR_IRQ_STATUS);
   wire wr_mask  = wr_i && (addr_i == ADDR_IRQ_MASK);
   wire wr_div   = wr_i && (addr_i == ADDR_CYCLE_DIV);
   wire rd_low   = rd_i && (addr_i == ADDR_COUNT_LOW);

   wire       counter_on           = timer_control_q[TC_ON_BIT];
   wire       eight_bit_select     = timer_control_q[TC_EIGHT_BIT];
   wire       source_select        = timer_control_q[TC_SRC_BIT];
   wire       edge_select          = timer_control_q[TC_EDGE_BIT];
   wire       prescaler_assignment = timer_control_q[TC_PSA_BIT];
   wire [2:0] prescale_ratio_field = timer_control_q[TC_PS_LSB +: TC_PS_W];

////////////////////////////////////////////////////////////////////////////////
// Instruction-cycle enable and edge detection.

   wire cycle_tick = (div_cnt_q == cycle_div_q);
   wire rise_seen  = ext_sync_q && !ext_prev_q;
   wire fall_seen  = !ext_sync_q && ext_prev_q;
   wire ext_edge   = edge_select ? fall_seen : rise_seen;
   // Edges are detected at master clock rate, so the increment lags the pin by
   // the two synchroniser stages plus one detection stage.
   wire src_event  = source_select ? ext_edge : cycle_tick;

   // Prescaler tap: bit n toggling low to high gives division by 2^(n+1).
   wire [7:0] pre_next  = prescaler_q + 8'h01;
   wire       pre_carry = pre_next[prescale_ratio_field] && !prescaler_q[prescale_ratio_field];
   wire       pre_out   = prescaler_assignment ? src_event : (src_event && pre_carry);

   wire holding   = (holdoff_q != 2'h0);
   wire count_inc = counter_on && pre_out && !holding && !wr_low && !wr_high;

   wire [15:0] count_full = {count_live_high_q, count_low_q};
   wire [15:0] count_next = count_full + 16'h0001;
   wire low_wrap  = (count_low_q == 8'hff);
   wire full_wrap = low_wrap && (count_live_high_q == 8'hff);
   wire overflow  = count_inc && (eight_bit_select ? low_wrap : full_wrap);

   // Read mux.
   wire [7:0] rd_mux =
      (addr_i == ADDR_COUNT_LOW)  ? count_low_q :
      (addr_i == ADDR_COUNT_HIGH) ? count_high_buffer_q :
      (addr_i == ADDR_TIMER_CTRL) ? timer_control_q :
      (addr_i == ADDR_INT_CTRL)   ? {int_ctrl_q[7:3], ovf_status_q, int_ctrl_q[1:0]} :
      (addr_i == ADDR_IRQ_STATUS) ? {7'h00, ovf_status_q} :
      (addr_i == ADDR_IRQ_MASK)   ? {7'h00, ovf_mask_q} :
      (addr_i == ADDR_CYCLE_DIV)  ? cycle_div_q : ZERO_BYTE;

   // The flag is cleared by writing zero through the control byte or one to status.
   wire flag_clear = (wr_ic && !wdata_i[IC_FLAG_BIT]) || (wr_st && wdata_i[ST_OVF_BIT]);
   wire flag_set_sw = wr_ic && wdata_i[IC_FLAG_BIT];

////////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge mclk_i) begin
      ext_meta_q <= external_count_input_i;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         div_cnt_q   <= ZERO_BYTE;
         cycle_div_q <= CYCLE_DIV_RST;
      end else begin
         div_cnt_q   <= cycle_tick ? ZERO_BYTE : div_cnt_q + 8'h01;
         if (wr_div) begin
            cycle_div_q <= wdata_i;
         end
      end
   end

   // While assigned to the timer the prescaler advances, and clears on a count write; it has no software read or write path.
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         prescaler_q <= ZERO_BYTE;
      end else if ((wr_low || wr_high) && !prescaler_assignment) begin
         prescaler_q <= ZERO_BYTE;
      end else if (src_event && !prescaler_assignment) begin
         prescaler_q <= pre_next;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         holdoff_q <= 2'h0;
      end else if (wr_low || wr_high) begin
         holdoff_q <= WRITE_HOLDOFF;
      end else if (holding && cycle_tick) begin
         holdoff_q <= holdoff_q - 2'h1;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         count_low_q         <= COUNT_LOW_RST;
         count_live_high_q   <= COUNT_HIGH_RST;
         count_high_buffer_q <= COUNT_HIGH_RST;
      end else begin
         if (wr_low) begin
            count_low_q       <= wdata_i;
            count_live_high_q <= count_high_buffer_q;
         end else if (count_inc) begin
            count_low_q <= count_next[7:0];
            if (!eight_bit_select) begin
               count_live_high_q <= count_next[15:8];
            end
         end
         if (rd_low) begin
            count_high_buffer_q <= count_live_high_q;
         end else if (wr_high) begin
            count_high_buffer_q <= wdata_i;
         end
      end
   end

   // Assignment and all control bits update immediately on any write.
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         timer_control_q <= TIMER_CTRL_RST;
      end else if (wr_tc) begin
         timer_control_q <= wdata_i;
      end
   end

   // A hardware overflow in the clearing cycle keeps the flag set.
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         int_ctrl_q   <= INT_CTRL_RST;
         ovf_status_q <= 1'b0;
         ovf_mask_q   <= 1'b0;
      end else begin
         if (wr_ic) begin
            int_ctrl_q <= wdata_i;
         end
         if (overflow || flag_set_sw) begin
            ovf_status_q <= 1'b1;
         end else if (flag_clear) begin
            ovf_status_q <= 1'b0;
         end
         if (wr_mask) begin
            ovf_mask_q <= wdata_i[ST_OVF_BIT];
         end
      end
   end

   // Both the control enable and the mask must be set; the flag stays sticky.
   wire irq_d = ovf_status_q && int_ctrl_q[IC_ENABLE_BIT] && ovf_mask_q;

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         rdata_o <= ZERO_BYTE;
         irq_o   <= 1'b0;
         wake_o  <= 1'b0;
      end else begin
         rdata_o <= rd_i ? rd_mux : ZERO_BYTE;
         irq_o   <= irq_d;
         wake_o  <= 1'b0;
      end
   end

endmodule

// ===== timer0_counter_pkg.sv
// Package for the 8/16-bit timer/counter: register map, field positions, reset values.
// Assumes a single 20 MHz clock domain and a plain strobe register port.
package timer0_counter_pkg;
   localparam int unsigned ADDR_W = 3;
   localparam int unsigned DATA_W = 8;
   // Register indices on the plain port.
   localparam logic [2:0] ADDR_COUNT_LOW   = 3'h0;
   localparam logic [2:0] ADDR_COUNT_HIGH  = 3'h1;
   localparam logic [2:0] ADDR_TIMER_CTRL  = 3'h2;
   localparam logic [2:0] ADDR_INT_CTRL    = 3'h3;
   localparam logic [2:0] ADDR_IRQ_STATUS  = 3'h4;
   localparam logic [2:0] ADDR_IRQ_MASK    = 3'h5;
   localparam logic [2:0] ADDR_CYCLE_DIV   = 3'h6;
   // Timer control fields.
   localparam int unsigned TC_ON_BIT     = 7;
   localparam int unsigned TC_EIGHT_BIT  = 6;
   localparam int unsigned TC_SRC_BIT    = 5;
   localparam int unsigned TC_EDGE_BIT   = 4;
   localparam int unsigned TC_PSA_BIT    = 3;
   localparam int unsigned TC_PS_LSB     = 0;
   localparam int unsigned TC_PS_W       = 3;
   // Interrupt control fields.
   localparam int unsigned IC_ENABLE_BIT = 5;
   localparam int unsigned IC_FLAG_BIT   = 2;
   // Status and mask: bit 0 is the overflow event.
   localparam int unsigned ST_OVF_BIT    = 0;
   // Reset values.
   localparam logic [7:0] TIMER_CTRL_RST = 8'hff;
   localparam logic [7:0] COUNT_HIGH_RST = 8'h00;
   localparam logic [7:0] COUNT_LOW_RST  = 8'h00;
   localparam logic [7:0] INT_CTRL_RST   = 8'h00;
   localparam logic [7:0] ZERO_BYTE      = 8'h00;
   // Write holdoff in instruction cycles.
   localparam logic [1:0] WRITE_HOLDOFF  = 2'h2;
   // Instruction cycle is four master clocks.
   localparam logic [7:0] CYCLE_DIV_RST  = 8'h03;
endpackage

// ===== timer0_counter_checker.sv
// Port-level checks of the timer/counter register port and interrupt pins.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
module timer0_counter_checker
   import timer0_counter_pkg::*;
(
   input wire logic              mclk_i,
   input wire logic              rst_n_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic              wr_i,
   input wire logic              rd_i,
   input wire logic              external_count_input_i,
   input wire logic              sleep_i,
   input wire logic [DATA_W-1:0] rdata_o,
   input wire logic              irq_o,
   input wire logic              wake_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   ////////////////////////////////////////
   a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data outside its slot");
   a_no_wake: assert property (wake_o == 1'b0)
      else $error("overflow woke the core");
   a_unmapped_read: assert property (rd_i && addr_i == 3'h7 |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_ctrl_readback: assert property (wr_i && addr_i == ADDR_TIMER_CTRL
      ##1 rd_i && addr_i == ADDR_TIMER_CTRL |=> rdata_o == $past(wdata_i, 2))
      else $error("control readback wrong");
   a_buffer_readback: assert property (wr_i && addr_i == ADDR_COUNT_HIGH
      ##1 rd_i && addr_i == ADDR_COUNT_HIGH |=> rdata_o == $past(wdata_i, 2))
      else $error("high buffer readback wrong");
   a_mask_off: assert property (wr_i && addr_i == ADDR_IRQ_MASK
      && !wdata_i[ST_OVF_BIT] |=> ##1 !irq_o)
      else $error("masked interrupt still high");
   a_enable_off: assert property (wr_i && addr_i == ADDR_INT_CTRL
      && !wdata_i[IC_ENABLE_BIT] |=> ##1 !irq_o)
      else $error("disabled interrupt still high");
   a_irq_held: assert property (irq_o && !wr_i && !$past(wr_i) |=> irq_o)
      else $error("interrupt dropped without a write");
endmodule

bind timer0_counter timer0_counter_checker i_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
   .external_count_input_i(external_count_input_i), .sleep_i(sleep_i),
   .rdata_o(rdata_o), .irq_o(irq_o), .wake_o(wake_o));

// ===== pulse_source.sv
// Pulse source on the count pin; it drives the pin at all times.
// Assumes the bench clock; every change follows a rising clock edge.
`timescale 1ns/1ps
module pulse_source (
   input  wire logic mclk_i,
   output logic      pin_o
);
   initial pin_o = 1'b0;
   // Ends high, so a burst shows n rising but only n-1 falling edges.
   task automatic send(input int n);
      for (int i = 0; i < n; i++) begin
         pin_o <= 1'b1;
         repeat (4) @(posedge mclk_i);
         if (i < n - 1) begin
            pin_o <= 1'b0;
            repeat (4) @(posedge mclk_i);
         end
      end
   endtask
   task automatic drop();
      pin_o <= 1'b0;
      repeat (8) @(posedge mclk_i);
   endtask
endmodule

// ===== testbench.sv
// Self-checking bench for the timer/counter: register tasks and directed sequences.
// Assumes the default divider of four clocks for each instruction cycle.
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
   $display("unexpected at %0t got %h exp %h", $time, a, e); end end
module testbench;
   import timer0_counter_pkg::*;
   logic              mclk_i = 1'b0;
   logic              rst_n_i = 1'b0;
   logic [ADDR_W-1:0] addr_i = '0;
   logic [DATA_W-1:0] wdata_i = '0;
   logic              wr_i = 1'b0;
   logic              rd_i = 1'b0;
   logic              sleep_i = 1'b0;
   logic              pin;
   logic              irq_o;
   logic              wake_o;
   logic [DATA_W-1:0] rdata_o;
   logic [7:0]        v0;
   logic [7:0]        v1;
   int                num_errors = 0;
   int                cmp_count = 0;
   timer0_counter i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .external_count_input_i(pin),
      .sleep_i(sleep_i), .rdata_o(rdata_o), .irq_o(irq_o), .wake_o(wake_o));
   pulse_source i_src (.mclk_i(mclk_i), .pin_o(pin));
   initial forever #25 mclk_i = ~mclk_i;
   ////////////////////////////////////////
   // The write strobe is held between writes, so back-to-back writes never toggle it.
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      wr_i <= 1'b0;
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      @(negedge mclk_i);
      d = rdata_o;
      @(posedge mclk_i);
   endtask
   task automatic gap(input int n);
      wr_i <= 1'b0;
      repeat (n) @(posedge mclk_i);
   endtask
   task automatic irq_is(input logic e);
      @(negedge mclk_i);
      `CHK(irq_o, e);
      @(posedge mclk_i);
   endtask
   task automatic wrap_up();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      gap(10);
      rst_n_i <= 1'b1;
      rd(ADDR_TIMER_CTRL, v0);
      `CHK(v0, 8'hff);
      rd(ADDR_COUNT_HIGH, v0);
      `CHK(v0, 8'h00);
      rd(3'h7, v0);
      `CHK(v0, 8'h00);
      wr(ADDR_TIMER_CTRL, 8'hc8);
      rd(ADDR_TIMER_CTRL, v0);
      `CHK(v0, 8'hc8);
      rd(ADDR_COUNT_LOW, v0);
      gap(38);
      rd(ADDR_COUNT_LOW, v1);
      `CHK(v1 - v0, 8'h0a);
      for (int n = 0; n < 3; n++) begin
         wr(ADDR_TIMER_CTRL, {5'h18, n[2:0]});
         rd(ADDR_COUNT_LOW, v0);
         gap((32 << n) - 2);
         rd(ADDR_COUNT_LOW, v1);
         `CHK(v1 - v0, 8'h04);
      end
      for (int e = 0; e < 2; e++) begin
         wr(ADDR_TIMER_CTRL, {3'h7, e[0], 4'h8});
         wr(ADDR_COUNT_LOW, 8'h00);
         gap(8);
         i_src.send(3);
         gap(8);
         rd(ADDR_COUNT_LOW, v0);
         `CHK(v0, 8'h03 - {7'h00, e[0]});
         i_src.drop();
         rd(ADDR_COUNT_LOW, v0);
         `CHK(v0, 8'h03);
      end
      wr(ADDR_TIMER_CTRL, 8'h08);
      wr(ADDR_COUNT_HIGH, 8'h12);
      rd(ADDR_COUNT_HIGH, v0);
      `CHK(v0, 8'h12);
      wr(ADDR_COUNT_LOW, 8'h34);
      wr(ADDR_COUNT_HIGH, 8'h56);
      rd(ADDR_COUNT_LOW, v0);
      `CHK(v0, 8'h34);
      rd(ADDR_COUNT_HIGH, v1);
      `CHK(v1, 8'h12);
      wr(ADDR_IRQ_MASK, 8'h01);
      wr(ADDR_INT_CTRL, 8'h20);
      wr(ADDR_TIMER_CTRL, 8'hc8);
      wr(ADDR_COUNT_LOW, 8'hfe);
      sleep_i <= 1'b1;
      gap(40);
      irq_is(1'b1);
      `CHK(wake_o, 1'b0);
      rd(ADDR_IRQ_STATUS, v0);
      `CHK(v0, 8'h01);
      rd(ADDR_INT_CTRL, v0);
      `CHK(v0, 8'h24);
      wr(ADDR_IRQ_MASK, 8'h00);
      gap(2);
      irq_is(1'b0);
      wr(ADDR_IRQ_MASK, 8'h01);
      gap(2);
      irq_is(1'b1);
      wr(ADDR_IRQ_STATUS, 8'h01);
      wr(ADDR_INT_CTRL, 8'h00);
      gap(2);
      irq_is(1'b0);
      wrap_up();
   end
   initial begin
      repeat (5000) @(posedge mclk_i);
      num_errors++;
      wrap_up();
   end
endmodule
